// *** spi_cfg_pkg.sv ***
package spi_cfg_pkg;

    // Frame layout: one direction bit, then a 15-bit register address
    localparam int          ADDR_W          = 15;
    localparam logic [3:0]  HDR_LAST_BIT    = 4'h000f;
    localparam logic [3:0]  BYTE_LAST_BIT   = 4'h0007;

    // Register offsets
    localparam logic [14:0] OFS_CONFIG_A    = 15'h0000;
    localparam logic [14:0] OFS_DEV_CFG     = 15'h0002;
    localparam logic [14:0] OFS_MAKER_LO    = 15'h000c;
    localparam logic [14:0] OFS_MAKER_HI    = 15'h000d;
    localparam logic [14:0] OFS_USR_CFG     = 15'h0010;

    // Field positions
    localparam int          SOFT_RESET_BIT  = 7;
    localparam int          ASCEND_BIT      = 5;
    localparam int          SDO_FLAG_BIT    = 4;
    localparam int          MODE_MSB        = 1;
    localparam int          HOLD_BIT        = 0;

    // Reset values and masks
    localparam logic [7:0]  CONFIG_A_RST    = 8'h0030;
    localparam logic [7:0]  DEV_CFG_RST     = 8'h0000;
    localparam logic [7:0]  USR_CFG_RST     = 8'h0000;
    localparam logic [7:0]  CONFIG_A_WMASK  = 8'h006f;
    localparam logic [7:0]  SDO_FLAG_MASK   = 8'h0010;

    // Operating field codes
    localparam logic [1:0]  MODE_NORMAL     = 2'h0;
    localparam logic [1:0]  MODE_POWER_DOWN = 2'h3;

    // Soft reset quiet period
    localparam int          CLK_MHZ         = 200;
    localparam int          RESET_TIME_NS   = 750;
    localparam int          RESET_CYCLES    = (RESET_TIME_NS * CLK_MHZ + 999) / 1000;
    localparam int          RST_CNT_W       = $clog2(RESET_CYCLES + 1);

    // Link phase, Gray coded
    typedef enum logic [1:0] {
        PH_HEADER = 2'b00,
        PH_DATA   = 2'b01
    } phase_t;

    // Register contents shown to the link side
    typedef struct packed {
        logic [7:0]  config_a;
        logic [7:0]  dev_cfg;
        logic [7:0]  usr_cfg;
        logic [15:0] maker;
    } reg_image_t;

    // One write byte handed from the link to the core
    typedef struct packed {
        logic [14:0] addr;
        logic [7:0]  data;
    } wr_word_t;

endpackage

// *** spi_config_register_bank.sv ***
`timescale 1ns/10ps
module spi_config_register_bank
    import spi_cfg_pkg::*;
#(
    parameter logic [15:0] MAKER_CODE = 16'h5a3c  // Arbitrary value
) (
    // Core clock and reset
    input  wire logic       clock_i,
    input  wire logic       rstn_i,
    // Serial control port
    input  wire logic       link_sclk_i,
    input  wire logic       link_csn_i,
    input  wire logic       link_sdi_i,
    output logic            link_sdo_o,
    // Device controls
    output logic            chip_reset_o,
    output logic [1:0]      operating_mode_o,
    output logic            power_down_o,
    output logic            address_ascend_o,
    output logic            address_hold_o
);

    typedef struct packed {
        logic [7:0]           config_a;
        logic [7:0]           dev_cfg;
        logic [7:0]           usr_cfg;
        logic                 tog_s1;
        logic                 tog_s2;
        logic                 tog_s3;
        logic                 chip_reset;
        logic [RST_CNT_W-1:0] rst_cnt;
        logic                 power_down;
        logic                 link_init;
    } core_t;

    localparam core_t CORE_RST = '{
        config_a:   CONFIG_A_RST,
        dev_cfg:    DEV_CFG_RST,
        usr_cfg:    USR_CFG_RST,
        tog_s1:     1'b0,
        tog_s2:     1'b0,
        tog_s3:     1'b0,
        chip_reset: 1'b0,
        rst_cnt:    '0,
        power_down: 1'b0,
        link_init:  1'b1
    };

    core_t      c_q, c_d;
    wr_word_t   wr_word;
    logic       wr_toggle;
    reg_image_t image;
    logic       wr_event;

    // Register image offered to the link side
    assign image = '{config_a: c_q.config_a, dev_cfg: c_q.dev_cfg,
                     usr_cfg: c_q.usr_cfg, maker: MAKER_CODE};

    // Link-domain serial engine
    spi_link_port u_link (
        .link_sclk_i (link_sclk_i),
        .link_csn_i  (link_csn_i),
        .link_sdi_i  (link_sdi_i),
        .link_sdo_o  (link_sdo_o),
        .link_init_i (c_q.link_init),
        .image_i     (image),
        .wr_word_o   (wr_word),
        .wr_toggle_o (wr_toggle)
    );

    // A write byte is ready when the synchronised toggle changes
    assign wr_event = c_q.tog_s2 ^ c_q.tog_s3;

    // Register writes and soft reset sequencing
    always_comb begin
        c_d = c_q;
        c_d.link_init = 1'b0;
        c_d.tog_s1 = wr_toggle;
        c_d.tog_s2 = c_q.tog_s1;
        c_d.tog_s3 = c_q.tog_s2;
        if (c_q.chip_reset) begin
            // Quiet period: hold the chip in reset, then release
            if (c_q.rst_cnt == '0) begin
                c_d.chip_reset = 1'b0;
            end else begin
                c_d.rst_cnt = c_q.rst_cnt - RST_CNT_W'(1);
            end
        end else if (wr_event) begin
            unique case (wr_word.addr)
                OFS_CONFIG_A: begin
                    if (wr_word.data[SOFT_RESET_BIT]) begin
                        c_d.config_a = CONFIG_A_RST;
                        c_d.dev_cfg = DEV_CFG_RST;
                        c_d.usr_cfg = USR_CFG_RST;
                        c_d.chip_reset = 1'b1;
                        c_d.rst_cnt = RST_CNT_W'(RESET_CYCLES - 1);
                    end else begin
                        // Reset bit never stored, flag bit forced to one
                        c_d.config_a = (wr_word.data & CONFIG_A_WMASK) | SDO_FLAG_MASK;
                    end
                end
                OFS_DEV_CFG: c_d.dev_cfg = wr_word.data;
                OFS_USR_CFG: c_d.usr_cfg = wr_word.data;
                default: ;
            endcase
        end
        c_d.power_down = (c_d.dev_cfg[MODE_MSB:0] == MODE_POWER_DOWN);
    end

    // State register
    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            c_q <= CORE_RST;
        end else begin
            c_q <= c_d;
        end
    end

    // Outputs straight from state flops
    assign chip_reset_o     = c_q.chip_reset;
    assign operating_mode_o = c_q.dev_cfg[MODE_MSB:0];
    assign power_down_o     = c_q.power_down;
    assign address_ascend_o = c_q.config_a[ASCEND_BIT];
    assign address_hold_o   = c_q.usr_cfg[HOLD_BIT];

endmodule // spi_config_register_bank

// *** spi_config_register_bank_props.sv ***
`timescale 1ns/10ps
module spi_config_register_bank_props
    import spi_cfg_pkg::*;
(
    // Core clock and reset
    input wire logic       clock_i,
    input wire logic       rstn_i,
    // Serial control port
    input wire logic       link_sclk_i,
    input wire logic       link_csn_i,
    input wire logic       link_sdi_i,
    input wire logic       link_sdo_o,
    // Device controls
    input wire logic       chip_reset_o,
    input wire logic [1:0] operating_mode_o,
    input wire logic       power_down_o,
    input wire logic       address_ascend_o,
    input wire logic       address_hold_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rstn_i);
    logic [3:0] quiet_q;
    // Cycles since select went high, saturating
    always_ff @(posedge clock_i) begin
        quiet_q <= (!rstn_i || !link_csn_i) ? 4'h0 : quiet_q + {3'h0, quiet_q != 4'hf};
    end
    AST_PD_FOLLOWS: assert property (power_down_o == (operating_mode_o == MODE_POWER_DOWN))
        else $error("power-down flag off its field");
    AST_SELF_CLEAR: assert property ($rose(chip_reset_o) |-> ##150 $fell(chip_reset_o))
        else $error("chip reset length wrong");
    AST_NO_RETRIG: assert property ($fell(chip_reset_o) |-> !chip_reset_o [*8])
        else $error("chip reset came back");
    AST_CLEARS: assert property (chip_reset_o |=> operating_mode_o == MODE_NORMAL
        && address_ascend_o && !address_hold_o) else $error("soft reset left state");
    AST_FROZEN: assert property (chip_reset_o && $past(chip_reset_o) |-> $stable(operating_mode_o))
        else $error("write taken during reset");
    AST_IDLE: assert property (quiet_q > 4'h8 |-> $stable({operating_mode_o, address_ascend_o,
        address_hold_o})) else $error("control changed without frame");
    AST_SDO_IDLE: assert property (link_csn_i && $past(link_csn_i) |-> !link_sdo_o)
        else $error("output line driven while deselected");
    AST_RST_VAL: assert property ($rose(rstn_i) |-> !chip_reset_o && !power_down_o
        && address_ascend_o && !address_hold_o && operating_mode_o == MODE_NORMAL)
        else $error("bad values after reset");
    // Main scenarios reached
    cover property ($rose(chip_reset_o));
    cover property (power_down_o);
    cover property (!address_ascend_o);
    cover property (address_hold_o);
endmodule // spi_config_register_bank_props

bind spi_config_register_bank spi_config_register_bank_props u_props (
    .clock_i(clock_i), .rstn_i(rstn_i), .link_sclk_i(link_sclk_i), .link_csn_i(link_csn_i),
    .link_sdi_i(link_sdi_i), .link_sdo_o(link_sdo_o), .chip_reset_o(chip_reset_o),
    .operating_mode_o(operating_mode_o), .power_down_o(power_down_o),
    .address_ascend_o(address_ascend_o), .address_hold_o(address_hold_o));

// *** spi_host_model.sv ***
`timescale 1ns/10ps
module spi_host_model (
    // Link pins
    output logic      link_sclk_o,
    output logic      link_csn_o,
    output logic      link_sdi_o,
    input  wire logic link_sdo_i
);
    // Clock parked low and select high outside frames
    initial begin
        link_sclk_o = 1'b0;
        link_csn_o = 1'b0;
        link_sdi_o = 1'b0;
        #1 link_csn_o = 1'b1; // Rising select clears the frame state
    end
    // One frame, mode 0, MSB first; write bytes top aligned
    task automatic xfer(input logic rd, input logic [14:0] a, input int n,
                        input logic [31:0] wd, output logic [31:0] q);
        logic [47:0] sh;
        sh = {rd, a, wd};
        q = 32'h0000_0000;
        #7 link_csn_o = 1'b0;
        for (int k = 0; k < 16 + 8 * n; k++) begin
            link_sdi_o = sh[47 - k];
            #15 link_sclk_o = 1'b1;
            q = {q[30:0], link_sdo_i};
            #15 link_sclk_o = 1'b0;
        end
        #15 link_csn_o = 1'b1;
        link_sdi_o = ~link_sdi_o; // Released line shows no stale bit
        #40;
    endtask
endmodule // spi_host_model

// *** spi_link_port.sv ***
`timescale 1ns/10ps
module spi_link_port
    import spi_cfg_pkg::*;
(
    // Link pins
    input  wire logic       link_sclk_i,
    input  wire logic       link_csn_i,
    input  wire logic       link_sdi_i,
    output logic            link_sdo_o,
    // Core side
    input  wire logic       link_init_i,
    input  wire reg_image_t image_i,
    output wr_word_t        wr_word_o,
    output logic            wr_toggle_o
);

    typedef struct packed {
        phase_t      phase;
        logic [3:0]  bcnt;
        logic [14:0] shift;
        logic        rd;
        logic [14:0] addr;
    } frame_t;

    typedef struct packed {
        reg_image_t  img_meta;
        reg_image_t  img_sync;
        wr_word_t    wr;
        logic        wr_tog;
    } keep_t;

    frame_t f_q, f_d;
    keep_t  k_q, k_d;
    logic   sdo_q;
    logic [7:0] rd_byte;

    // Read data for the current streaming address
    always_comb begin
        unique case (f_q.addr)
            OFS_CONFIG_A: rd_byte = k_q.img_sync.config_a | SDO_FLAG_MASK;
            OFS_DEV_CFG:  rd_byte = k_q.img_sync.dev_cfg;
            OFS_MAKER_LO: rd_byte = k_q.img_sync.maker[7:0];
            OFS_MAKER_HI: rd_byte = k_q.img_sync.maker[15:8];
            OFS_USR_CFG:  rd_byte = k_q.img_sync.usr_cfg;
            default:      rd_byte = 8'h0000;
        endcase
    end

    // Header decode, byte counting and address stepping
    always_comb begin
        f_d = f_q;
        k_d = k_q;
        // Image sampled only during the header, while core writes have settled
        if (f_q.phase == PH_HEADER) begin
            k_d.img_meta = image_i;
            k_d.img_sync = k_q.img_meta;
        end
        f_d.shift = {f_q.shift[13:0], link_sdi_i};
        f_d.bcnt = f_q.bcnt + 4'h0001;
        unique case (f_q.phase)
            PH_HEADER: begin
                if (f_q.bcnt == HDR_LAST_BIT) begin
                    f_d.rd = f_q.shift[14];
                    f_d.addr = {f_q.shift[13:0], link_sdi_i};
                    f_d.bcnt = 4'h0000;
                    f_d.phase = PH_DATA;
                end
            end
            PH_DATA: begin
                if (f_q.bcnt == BYTE_LAST_BIT) begin
                    f_d.bcnt = 4'h0000;
                    if (!f_q.rd) begin
                        k_d.wr.addr = f_q.addr;
                        k_d.wr.data = {f_q.shift[6:0], link_sdi_i};
                        k_d.wr_tog = ~k_q.wr_tog;
                    end
                    if (!k_q.img_sync.usr_cfg[HOLD_BIT]) begin
                        if (k_q.img_sync.config_a[ASCEND_BIT]) begin
                            f_d.addr = f_q.addr + 15'h0001;
                        end else begin
                            f_d.addr = f_q.addr - 15'h0001;
                        end
                    end
                end
            end
        endcase
    end

    // Frame state, cleared whenever chip select is high
    always_ff @(posedge link_sclk_i or posedge link_csn_i) begin
        if (link_csn_i) begin
            f_q <= '{phase: PH_HEADER, bcnt: 4'h0000, shift: 15'h0000,
                     rd: 1'b0, addr: 15'h0000};
        end else begin
            f_q <= f_d;
        end
    end

    // Cross-frame state, cleared by the core reset
    always_ff @(posedge link_sclk_i or posedge link_init_i) begin
        if (link_init_i) begin
            k_q <= '{img_meta: '{CONFIG_A_RST, DEV_CFG_RST, USR_CFG_RST, 16'h0000},
                     img_sync: '{CONFIG_A_RST, DEV_CFG_RST, USR_CFG_RST, 16'h0000},
                     wr: '{addr: 15'h0000, data: 8'h0000}, wr_tog: 1'b0};
        end else begin
            k_q <= k_d;
        end
    end

    // Serial output on the falling edge, only on the separate output line
    always_ff @(negedge link_sclk_i or posedge link_csn_i) begin
        if (link_csn_i) begin
            sdo_q <= 1'b0;
        end else begin
            sdo_q <= (f_q.phase == PH_DATA) && f_q.rd && rd_byte[~f_q.bcnt[2:0]];
        end
    end

    assign link_sdo_o  = sdo_q;
    assign wr_word_o   = k_q.wr;
    assign wr_toggle_o = k_q.wr_tog;

endmodule // spi_link_port

// *** test_spi_config_register_bank.sv ***
`timescale 1ns/10ps
module test_spi_config_register_bank
    import spi_cfg_pkg::*;
();
    localparam logic [15:0] CODE = 16'h6b29; // Arbitrary value
    logic        clock_i = 1'b0;
    logic        rstn_i = 1'b0;
    logic        sclk, csn, sdi, sdo, crst, pd, asc, hold;
    logic [1:0]  mode;
    logic [31:0] q;
    int          fail_count = 0;
    int          cmp_count = 0;
    int          i;

    // Core clock
    always #2.5 clock_i = ~clock_i;

    spi_config_register_bank #(.MAKER_CODE(CODE)) DUT (
        .clock_i(clock_i), .rstn_i(rstn_i), .link_sclk_i(sclk), .link_csn_i(csn),
        .link_sdi_i(sdi), .link_sdo_o(sdo), .chip_reset_o(crst), .operating_mode_o(mode),
        .power_down_o(pd), .address_ascend_o(asc), .address_hold_o(hold));
    spi_host_model host (.link_sclk_o(sclk), .link_csn_o(csn), .link_sdi_o(sdi), .link_sdo_i(sdo));

    // Compare a read byte
    task automatic chk_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            fail_count++;
            $display("FAIL %s exp %h got %h", nm, e, g);
        end
    endtask
    // Compare {chip reset, mode, power-down, ascend, hold} off the clock edge
    task automatic chk_pin(input string nm, input logic [5:0] e);
        @(posedge clock_i);
        #1;
        cmp_count++;
        if ({crst, mode, pd, asc, hold} !== e) begin
            fail_count++;
            $display("FAIL %s exp %b got %b", nm, e, {crst, mode, pd, asc, hold});
        end
    endtask
    // Register frames
    task automatic wr(input logic [14:0] a, input int n, input logic [31:0] d);
        host.xfer(1'b0, a, n, d, q);
    endtask
    task automatic rd(input logic [14:0] a, input int n);
        host.xfer(1'b1, a, n, 32'h0000_0000, q);
    endtask
    // Counts and verdict
    task automatic print_verdict();
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Test sequence
    initial begin
        repeat (2) @(posedge clock_i);
        #1 rstn_i = 1'b1;
        repeat (2) @(posedge clock_i);
        chk_pin("reset pins", 6'b000010);
        rd(OFS_CONFIG_A, 1);
        chk_byte("config_a", 8'h30, q[7:0]);
        wr(OFS_MAKER_LO, 1, 32'hff00_0000);
        rd(OFS_MAKER_LO, 2);
        chk_byte("maker lo", CODE[7:0], q[15:8]);
        chk_byte("maker hi", CODE[15:8], q[7:0]);
        rd(15'h0001, 1);
        chk_byte("unmapped", 8'h00, q[7:0]);
        $display("test identity done");
        wr(OFS_CONFIG_A, 1, 32'h0000_0000);
        chk_pin("descend", 6'b000000);
        rd(OFS_CONFIG_A, 1);
        chk_byte("ro flag", 8'h10, q[7:0]);
        rd(OFS_MAKER_HI, 2);
        chk_byte("desc first", CODE[15:8], q[15:8]);
        chk_byte("desc next", CODE[7:0], q[7:0]);
        $display("test descend done");
        wr(OFS_USR_CFG, 1, 32'h0100_0000);
        rd(OFS_MAKER_LO, 2);
        chk_byte("hold first", CODE[7:0], q[15:8]);
        chk_byte("hold next", CODE[7:0], q[7:0]);
        wr(OFS_DEV_CFG, 2, 32'h0300_0000);
        chk_pin("hold write", 6'b000001);
        wr(OFS_USR_CFG, 1, 32'h0000_0000);
        wr(OFS_CONFIG_A, 1, 32'h3000_0000);
        wr(OFS_CONFIG_A, 3, 32'h3000_0300);
        chk_pin("step write", 6'b011110);
        rd(OFS_DEV_CFG, 1);
        chk_byte("mode field", 8'h03, q[7:0]);
        $display("test stream done");
        wr(OFS_USR_CFG, 1, 32'h0100_0000);
        wr(OFS_CONFIG_A, 1, 32'h8000_0000);
        chk_pin("soft reset", 6'b100010);
        for (i = 0; i < 400 && crst === 1'b1; i++) begin
            @(posedge clock_i);
        end
        if (i == 400) begin
            fail_count++;
            $display("FAIL chip reset release exp 0 got %b", crst);
        end else begin
            rd(OFS_CONFIG_A, 1);
            chk_byte("self clear", 8'h30, q[7:0]);
            rd(OFS_USR_CFG, 1);
            chk_byte("usr cleared", 8'h00, q[7:0]);
            chk_pin("after reset", 6'b000010);
        end
        $display("test soft reset done");
        print_verdict();
    end
endmodule // test_spi_config_register_bank
